//--- rtl/adc_control_and_result_regs.sv
// apb register file, channel and reference steering, conversion control of the converter
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "adc_params.svh"

// Function
// - channel codes 00000 to 00100 route external analog inputs 0 to 4
// - code 11111 fixed reference, 11101 temperature, 11010 positive reference
// - every other channel code connects nothing to the converter
// - writing one to bit 1 starts conversion; reads one while running
// - hardware clears the status bit when conversion finishes
// - bit 0 enables the converter; zero powers it down
// - bit 7 of control register 0 always reads zero
// - right justified load zeroes six upper bits of high result
// - left justified load zeroes six lower bits of low result
// - clock codes 000,001,010,100,101,110 divide by 2,8,32,4,16,64
// - clock codes 011 and 111 select the rc oscillator
// - reference codes: 00 supply, 10 external pin, 11 fixed, 01 reserved
// - left justified high result holds result bits 9 to 2
// - left justified low result bits 7 to 6 hold result 1 to 0
// - right justified high result bits 1 to 0 hold result 9 to 8
// - right justified low result holds result bits 7 to 0
// - control registers reset to zero; result registers are never reset
// - the hold capacitor is never discharged after a conversion
// - completion clears status bit, sets done flag, loads both results
// - clearing status bit mid conversion loads partial result, filled with last bit
module adc_control_and_result_regs #(
   parameter int ADDR_W = 8,
   parameter int DIV_CNT_W = 7
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comparator_high,
   input wire logic rc_osc_tick,
   output logic converter_power,
   output logic sample_connect,
   output logic [`RESULT_BITS-1:0] trial_code,
   output logic [4:0] ext_channel_select,
   output logic fixed_ref_select,
   output logic temp_sensor_select,
   output logic pos_ref_to_input,
   output logic ref_supply_select,
   output logic ref_ext_pin_select,
   output logic ref_fixed_select,
   output logic conv_done_flag
);
   localparam int RES_W = `RESULT_BITS;

   logic [7:0] ctrl0;
   logic [7:0] next_ctrl0;
   logic [7:0] ctrl1;
   logic [7:0] next_ctrl1;
   logic next_done_flag;
   logic [7:0] result_high;
   logic [7:0] next_result_high;
   logic [7:0] result_low;
   logic [7:0] next_result_low;
   logic [31:0] next_prdata;
   logic setup_phase;
   logic access_phase;
   logic wr_access;
   logic hit_ctrl0;
   logic hit_ctrl1;
   logic hit_high;
   logic hit_low;
   logic hit_status;
   logic mapped;
   logic start_conv;
   logic abort_conv;
   logic eng_busy;
   logic eng_done;
   logic [RES_W-1:0] eng_result;
   logic tad_tick;
   logic [4:0] next_chan;
   logic [1:0] next_ref;
   logic [4:0] next_ext;
   logic next_fixed;
   logic next_temp;
   logic next_pos_ref;
   logic next_ref_supply;
   logic next_ref_ext;
   logic next_ref_fixed;
   logic next_power;
   logic next_sample;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // zero wait states: every access phase completes at its first edge
   always_comb begin
      setup_phase = psel && !penable;
      access_phase = psel && penable;
      hit_ctrl0 = paddr == ADDR_W'(`OFS_CONV_CONTROL_0);
      hit_ctrl1 = paddr == ADDR_W'(`OFS_CONV_CONTROL_1);
      hit_high = paddr == ADDR_W'(`OFS_RESULT_HIGH);
      hit_low = paddr == ADDR_W'(`OFS_RESULT_LOW);
      hit_status = paddr == ADDR_W'(`OFS_CONV_STATUS);
      mapped = hit_ctrl0 || hit_ctrl1 || hit_high || hit_low || hit_status;
      wr_access = access_phase && pwrite && mapped;
      pready = access_phase;
      pslverr = access_phase && !mapped;
   end

   // ---------------------------------------------------------------
   // control registers and conversion handshake
   // ---------------------------------------------------------------
   always_comb begin
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_done_flag = conv_done_flag;
      start_conv = 1'b0;
      abort_conv = 1'b0;
      if (eng_done) begin
         next_ctrl0[`CTRL0_GO_BIT] = 1'b0;
      end
      if (wr_access && hit_ctrl0) begin
         next_ctrl0 = pwdata[7:0] & `CTRL0_WRITE_MASK;
         next_ctrl0[`CTRL0_GO_BIT] = ctrl0[`CTRL0_GO_BIT] && !eng_done;
         // a start needs the converter already on, as the go bit should
         // not be set in the same write that powers it up
         if (pwdata[`CTRL0_GO_BIT] && pwdata[`CTRL0_ENABLE_BIT] && ctrl0[`CTRL0_ENABLE_BIT]
             && !ctrl0[`CTRL0_GO_BIT] && !eng_busy) begin
            start_conv = 1'b1;
            next_ctrl0[`CTRL0_GO_BIT] = 1'b1;
         end else if (ctrl0[`CTRL0_GO_BIT] && eng_busy
                      && (!pwdata[`CTRL0_GO_BIT] || !pwdata[`CTRL0_ENABLE_BIT])) begin
            // clearing go or switching off ends the conversion early
            abort_conv = 1'b1;
            next_ctrl0[`CTRL0_GO_BIT] = 1'b0;
         end
      end
      if (wr_access && hit_ctrl1) begin
         next_ctrl1 = pwdata[7:0] & `CTRL1_WRITE_MASK;
      end
      if (wr_access && hit_status && pwdata[`STATUS_FLAG_BIT]) begin
         next_done_flag = 1'b0;
      end
      // a completion in the cycle of a clear still leaves the flag set
      if (eng_done) begin
         next_done_flag = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // result registers
   // ---------------------------------------------------------------
   // a load from the converter wins over a software write in the same cycle
   always_comb begin
      next_result_high = result_high;
      next_result_low = result_low;
      if (wr_access && hit_high) begin
         next_result_high = pwdata[7:0];
      end
      if (wr_access && hit_low) begin
         next_result_low = pwdata[7:0];
      end
      if (eng_done) begin
         if (ctrl1[`CTRL1_FORMAT_BIT]) begin
            next_result_high = {6'h00, eng_result[9:8]};
            next_result_low = eng_result[7:0];
         end else begin
            next_result_high = eng_result[9:2];
            next_result_low = {eng_result[1:0], 6'h00};
         end
      end
   end

   // no reset: contents survive every reset and start unknown
   always_ff @(posedge clock) begin
      result_high <= next_result_high;
      result_low <= next_result_low;
   end

   // ---------------------------------------------------------------
   // read data, captured in the setup phase
   // ---------------------------------------------------------------
   always_comb begin
      next_prdata = prdata;
      if (setup_phase) begin
         next_prdata = 32'h00000000;
         if (hit_ctrl0) begin
            next_prdata[7:0] = ctrl0 & `CTRL0_WRITE_MASK;
         end else if (hit_ctrl1) begin
            next_prdata[7:0] = ctrl1 & `CTRL1_WRITE_MASK;
         end else if (hit_high) begin
            next_prdata[7:0] = result_high;
         end else if (hit_low) begin
            next_prdata[7:0] = result_low;
         end else if (hit_status) begin
            next_prdata[`STATUS_FLAG_BIT] = conv_done_flag;
            next_prdata[`STATUS_BUSY_BIT] = eng_busy;
         end
      end
   end

   // ---------------------------------------------------------------
   // analog steering
   // ---------------------------------------------------------------
   // decoded from the next control values so the selects change together
   // with the register bits that steer them
   always_comb begin
      next_chan = next_ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB];
      next_ref = next_ctrl1[`CTRL1_REF_MSB:`CTRL1_REF_LSB];
      next_ext = 5'h00;
      if (next_chan <= `CHAN_LAST_EXT) begin
         next_ext[next_chan[2:0]] = 1'b1;
      end
      // any code not matched here leaves every select low
      next_fixed = next_chan == `CHAN_FIXED_REF;
      next_temp = next_chan == `CHAN_TEMP;
      next_pos_ref = next_chan == `CHAN_POS_REF;
      // the reserved reference code selects nothing
      next_ref_supply = next_ref == `REF_SUPPLY;
      next_ref_ext = next_ref == `REF_EXT_PIN;
      next_ref_fixed = next_ref == `REF_FIXED;
      next_power = next_ctrl0[`CTRL0_ENABLE_BIT];
      // the hold capacitor tracks the input between conversions while enabled and is
      // disconnected while converting or disabled; there is no discharge path
      next_sample = next_ctrl0[`CTRL0_ENABLE_BIT] && !next_ctrl0[`CTRL0_GO_BIT];
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctrl0 <= `CTRL0_RESET;
         ctrl1 <= `CTRL1_RESET;
         conv_done_flag <= 1'b0;
         prdata <= 32'h00000000;
         ext_channel_select <= 5'h01;
         fixed_ref_select <= 1'b0;
         temp_sensor_select <= 1'b0;
         pos_ref_to_input <= 1'b0;
         ref_supply_select <= 1'b1;
         ref_ext_pin_select <= 1'b0;
         ref_fixed_select <= 1'b0;
         converter_power <= 1'b0;
         sample_connect <= 1'b0;
      end else begin
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         conv_done_flag <= next_done_flag;
         prdata <= next_prdata;
         ext_channel_select <= next_ext;
         fixed_ref_select <= next_fixed;
         temp_sensor_select <= next_temp;
         pos_ref_to_input <= next_pos_ref;
         ref_supply_select <= next_ref_supply;
         ref_ext_pin_select <= next_ref_ext;
         ref_fixed_select <= next_ref_fixed;
         converter_power <= next_power;
         sample_connect <= next_sample;
      end
   end

   // ---------------------------------------------------------------
   // conversion clock and sequencer
   // ---------------------------------------------------------------
   // the divider idles while the converter is off to save switching
   conv_clock_divider #(
      .CNT_W(DIV_CNT_W)
   ) u_divider (
      .clock(clock),
      .rst_b(rst_b),
      .enable(ctrl0[`CTRL0_ENABLE_BIT]),
      .clock_code(ctrl1[`CTRL1_CLK_MSB:`CTRL1_CLK_LSB]),
      .rc_osc_tick(rc_osc_tick),
      .tad_tick(tad_tick)
   );

   sar_engine #(
      .RES_W(RES_W)
   ) u_sar (
      .clock(clock),
      .rst_b(rst_b),
      .start(start_conv),
      .abort(abort_conv),
      .tad_tick(tad_tick),
      .comparator_high(comparator_high),
      .busy(eng_busy),
      .done(eng_done),
      .result(eng_result),
      .trial_code(trial_code)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking main_cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence ctrl0_write_s;
      access_phase && pwrite && hit_ctrl0;
   endsequence

   sequence go_request_s;
      ctrl0_write_s ##0 (pwdata[`CTRL0_GO_BIT] && pwdata[`CTRL0_ENABLE_BIT]
         && ctrl0[`CTRL0_ENABLE_BIT] && !ctrl0[`CTRL0_GO_BIT] && !eng_busy);
   endsequence

   AST_GO_START: assert property (go_request_s |=> ctrl0[`CTRL0_GO_BIT] && eng_busy)
      else $error("go write did not start a conversion");

   AST_GO_HOLDS: assert property (
      ctrl0[`CTRL0_GO_BIT] && eng_busy && !(access_phase && pwrite && hit_ctrl0)
      |=> ctrl0[`CTRL0_GO_BIT])
      else $error("go bit dropped while converting");

   AST_GO_CLEARS: assert property (eng_done && !start_conv |=> !ctrl0[`CTRL0_GO_BIT])
      else $error("go bit not cleared at completion");

   AST_POWER_OFF: assert property (
      !ctrl0[`CTRL0_ENABLE_BIT] |-> !converter_power && !sample_connect)
      else $error("converter powered while disabled");

   AST_BIT7_ZERO: assert property (
      setup_phase && !pwrite && hit_ctrl0 |=> pready && prdata[7] == 1'b0)
      else $error("unimplemented control bit read as one");

   AST_CHAN_EXT: assert property (
      ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] <= `CHAN_LAST_EXT
      |-> ext_channel_select == (5'h01 << ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB])
      && !fixed_ref_select && !temp_sensor_select && !pos_ref_to_input)
      else $error("external channel not routed");

   AST_CHAN_INT: assert property (
      ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] == `CHAN_TEMP
      |-> temp_sensor_select && !fixed_ref_select && !pos_ref_to_input
      && ext_channel_select == 5'h00)
      else $error("temperature channel not routed alone");

   AST_CHAN_NONE: assert property (
      ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] > `CHAN_LAST_EXT
      && ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] != `CHAN_FIXED_REF
      && ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] != `CHAN_TEMP
      && ctrl0[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] != `CHAN_POS_REF
      |-> ext_channel_select == 5'h00 && !fixed_ref_select && !temp_sensor_select
      && !pos_ref_to_input)
      else $error("reserved channel code connected a source");

   AST_REF_EXT: assert property (
      ctrl1[`CTRL1_REF_MSB:`CTRL1_REF_LSB] == `REF_EXT_PIN
      |-> ref_ext_pin_select && !ref_supply_select && !ref_fixed_select)
      else $error("external reference not selected alone");

   AST_RIGHT_JUST: assert property (
      eng_done && ctrl1[`CTRL1_FORMAT_BIT]
      |=> result_high == {6'h00, eng_result[9:8]} && result_low == eng_result[7:0])
      else $error("right justified result wrong");

   AST_LEFT_JUST: assert property (
      eng_done && !ctrl1[`CTRL1_FORMAT_BIT]
      |=> result_high == eng_result[9:2] && result_low == {eng_result[1:0], 6'h00})
      else $error("left justified result wrong");

   AST_DONE_FLAG: assert property (eng_done |=> conv_done_flag)
      else $error("done flag not set at completion");

   AST_ABORT: assert property (abort_conv |=> eng_done ##1 !eng_busy)
      else $error("abort did not end the conversion at once");

   AST_NO_START_OFF: assert property (
      ctrl0_write_s ##0 !ctrl0[`CTRL0_ENABLE_BIT] |=> !ctrl0[`CTRL0_GO_BIT] && !eng_busy)
      else $error("conversion started while disabled");
endmodule

//--- rtl/adc_params.svh
// register offsets, field positions, reset values and clock ratios of the converter block
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
`define OFS_CONV_CONTROL_0 8'h00
`define OFS_CONV_CONTROL_1 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_CONV_STATUS 8'h10
`define CTRL0_ENABLE_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL0_CHAN_LSB 2
`define CTRL0_CHAN_MSB 6
`define CTRL1_REF_LSB 0
`define CTRL1_REF_MSB 1
`define CTRL1_CLK_LSB 4
`define CTRL1_CLK_MSB 6
`define CTRL1_FORMAT_BIT 7
`define STATUS_FLAG_BIT 0
`define STATUS_BUSY_BIT 1
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define CTRL0_WRITE_MASK 8'h7F
`define CTRL1_WRITE_MASK 8'hF3
`define RESULT_BITS 10
`define CHAN_LAST_EXT 5'h04
`define CHAN_POS_REF 5'h1A
`define CHAN_TEMP 5'h1D
`define CHAN_FIXED_REF 5'h1F
`define REF_SUPPLY 2'h0
`define REF_EXT_PIN 2'h2
`define REF_FIXED 2'h3
`define CLK_DIV2 3'h0
`define CLK_DIV8 3'h1
`define CLK_DIV32 3'h2
`define CLK_DIV4 3'h4
`define CLK_DIV16 3'h5
`define CLK_DIV64 3'h6
`define RATIO_DIV2 2
`define RATIO_DIV4 4
`define RATIO_DIV8 8
`define RATIO_DIV16 16
`define RATIO_DIV32 32
`define RATIO_DIV64 64
`endif

//--- rtl/adc_pkg.sv
// shared types of the converter block
package adc_pkg;
   typedef enum logic [1:0] {SAR_IDLE, SAR_HOLD, SAR_TRIAL} sar_state_t;
endpackage

//--- rtl/conv_clock_divider.sv
// conversion clock enable: system clock division or the rc oscillator tick
`timescale 1ns/1ps
`include "adc_params.svh"

module conv_clock_divider #(
   parameter int CNT_W = 7
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic [2:0] clock_code,
   input wire logic rc_osc_tick,
   output logic tad_tick
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic next_tick;
   logic rc_mode;

   function automatic logic [CNT_W-1:0] ratio(input logic [2:0] code);
      case (code)
         `CLK_DIV2: ratio = CNT_W'(`RATIO_DIV2);
         `CLK_DIV4: ratio = CNT_W'(`RATIO_DIV4);
         `CLK_DIV8: ratio = CNT_W'(`RATIO_DIV8);
         `CLK_DIV16: ratio = CNT_W'(`RATIO_DIV16);
         `CLK_DIV32: ratio = CNT_W'(`RATIO_DIV32);
         `CLK_DIV64: ratio = CNT_W'(`RATIO_DIV64);
         default: ratio = CNT_W'(`RATIO_DIV2);
      endcase
   endfunction

   assign rc_mode = clock_code[1] && clock_code[0];

   always_comb begin
      next_count = count;
      next_tick = 1'b0;
      if (!enable) begin
         next_count = '0;
      end else if (rc_mode) begin
         next_count = '0;
         next_tick = rc_osc_tick;
      end else if (count >= ratio(clock_code) - 1'b1) begin
         next_count = '0;
         next_tick = 1'b1;
      end else begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
         tad_tick <= 1'b0;
      end else begin
         count <= next_count;
         tad_tick <= next_tick;
      end
   end

   AST_DIV2_PERIOD: assert property (@(posedge clock) disable iff (!rst_b)
      (tad_tick && enable && clock_code == `CLK_DIV2) ##1 (enable && clock_code == `CLK_DIV2)
      |-> !tad_tick ##1 tad_tick)
      else $error("divide by two tick spacing wrong");

   AST_RC_TICK: assert property (@(posedge clock) disable iff (!rst_b)
      enable && rc_mode |=> tad_tick == $past(rc_osc_tick))
      else $error("rc oscillator tick not passed through");
endmodule

//--- rtl/sar_engine.sv
// successive approximation sequencer with abort and partial result fill
`timescale 1ns/1ps

module sar_engine #(
   parameter int RES_W = 10
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic abort,
   input wire logic tad_tick,
   input wire logic comparator_high,
   output logic busy,
   output logic done,
   output logic [RES_W-1:0] result,
   output logic [RES_W-1:0] trial_code
);
   localparam int IDX_W = $clog2(RES_W);
   localparam logic [IDX_W-1:0] TOP = IDX_W'(RES_W - 1);

   adc_pkg::sar_state_t state;
   adc_pkg::sar_state_t next_state;
   logic [RES_W-1:0] bits;
   logic [RES_W-1:0] next_bits;
   logic [RES_W-1:0] next_result;
   logic [RES_W-1:0] next_trial;
   logic [IDX_W-1:0] idx;
   logic [IDX_W-1:0] next_idx;
   logic next_done;
   logic last_bit;

   assign busy = state != adc_pkg::SAR_IDLE;

   always_comb begin
      next_state = state;
      next_bits = bits;
      next_idx = idx;
      next_done = 1'b0;
      next_result = result;
      last_bit = 1'b0;
      case (state)
         adc_pkg::SAR_IDLE: begin
            if (start) begin
               next_state = adc_pkg::SAR_HOLD;
               next_bits = '0;
               next_idx = TOP;
            end
         end
         adc_pkg::SAR_HOLD: begin
            // one conversion clock for the hold capacitor to leave the input
            if (abort) begin
               next_state = adc_pkg::SAR_IDLE;
               next_done = 1'b1;
               next_result = '0;
            end else if (tad_tick) begin
               next_state = adc_pkg::SAR_TRIAL;
            end
         end
         adc_pkg::SAR_TRIAL: begin
            if (abort) begin
               next_state = adc_pkg::SAR_IDLE;
               next_done = 1'b1;
               if (idx != TOP) begin
                  last_bit = bits[idx + 1'b1];
               end
               for (int i = 0; i < RES_W; i++) begin
                  next_result[i] = (i <= int'(idx)) ? last_bit : bits[i];
               end
            end else if (tad_tick) begin
               next_bits[idx] = comparator_high;
               if (idx == '0) begin
                  next_state = adc_pkg::SAR_IDLE;
                  next_done = 1'b1;
                  next_result = next_bits;
               end else begin
                  next_idx = idx - 1'b1;
               end
            end
         end
         default: next_state = adc_pkg::SAR_IDLE;
      endcase
      next_trial = next_bits;
      if (next_state == adc_pkg::SAR_TRIAL) begin
         next_trial[next_idx] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= adc_pkg::SAR_IDLE;
         bits <= '0;
         idx <= '0;
         done <= 1'b0;
         result <= '0;
         trial_code <= '0;
      end else begin
         state <= next_state;
         bits <= next_bits;
         idx <= next_idx;
         done <= next_done;
         result <= next_result;
         trial_code <= next_trial;
      end
   end
endmodule

//--- tb/adc_control_and_result_regs_tb_top.sv
// self-checking bench of the converter register block
`timescale 1ns/1ps
`include "adc_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("Error %0t: got %0h want %0h", $time, a, b); end end

module adc_control_and_result_regs_tb_top;
   logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, comp, tick, pwr, smp, fixs, temps, posr, rsup, rext, rfix, flag;
   logic [9:0] trial, level = 10'h000;
   logic [4:0] ext;
   int n_fail = 0, checked = 0, cyc = 0, t, v, r, hi, lo;
   int ratio[8] = '{2, 8, 32, 5, 4, 16, 64, 5};

   adc_control_and_result_regs i_adc_control_and_result_regs (.clock(clock), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_high(comp),
      .rc_osc_tick(tick), .converter_power(pwr), .sample_connect(smp), .trial_code(trial),
      .ext_channel_select(ext), .fixed_ref_select(fixs), .temp_sensor_select(temps),
      .pos_ref_to_input(posr), .ref_supply_select(rsup), .ref_ext_pin_select(rext),
      .ref_fixed_select(rfix), .conv_done_flag(flag));
   analog_front_model i_analog_front_model (.clock(clock), .level(level), .trial_code(trial),
      .comparator_high(comp), .rc_osc_tick(tick));

   initial forever #20 clock = ~clock;

   task automatic print_verdict();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // hangs are cut short here
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         print_verdict();
      end
   end

   // one apb transfer; the trailing edge keeps back-to-back calls from racing
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic results();
      xfer(1'b0, `OFS_RESULT_HIGH, 32'h0);
      `CHK(q, hi)
      xfer(1'b0, `OFS_RESULT_LOW, 32'h0);
      `CHK(q, lo)
   endtask

   initial begin
      void'($urandom(32'h9d7f));
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      xfer(1'b0, `OFS_CONV_CONTROL_1, 32'h0);
      `CHK(q, 32'h0)
      xfer(1'b1, `OFS_CONV_CONTROL_0, 32'hFF);
      xfer(1'b0, `OFS_CONV_CONTROL_0, 32'h0);
      `CHK(q, 32'h7D)
      xfer(1'b0, 8'h14, 32'h0);
      `CHK({err, q}, {1'b1, 32'h0})
      for (int c = 0; c < 32; c++) begin
         xfer(1'b1, `OFS_CONV_CONTROL_0, 32'(c << 2));
         @(posedge clock);
         `CHK(ext, (c <= 4) ? 5'(1 << c) : 5'h00)
         `CHK({fixs, temps, posr}, {c == 31, c == 29, c == 26})
      end
      // every clock code in both formats, random level and reference
      for (int k = 0; k < 16; k++) begin
         v = $urandom_range(1023, 0);
         r = $urandom_range(3, 0);
         level <= 10'(v);
         xfer(1'b1, `OFS_CONV_CONTROL_1, {24'h0, k[0], k[3:1], 2'b00, r[1:0]});
         xfer(1'b1, `OFS_CONV_CONTROL_0, 32'h01);
         repeat (4) @(posedge clock);
         `CHK({rfix, rext, rsup, pwr}, {r == 3, r == 2, r == 0, 1'b1})
         xfer(1'b1, `OFS_CONV_CONTROL_0, 32'h03);
         xfer(1'b0, `OFS_CONV_CONTROL_0, 32'h0);
         `CHK(q, 32'h03)
         `CHK(smp, 1'b0)
         xfer(1'b0, `OFS_CONV_STATUS, 32'h0);
         `CHK(q, 32'h02)
         t = 0;
         while (flag !== 1'b1) begin
            @(posedge clock);
            t++;
         end
         `CHK(t >= 10 * ratio[k / 2] - 6 && t <= 11 * ratio[k / 2] + 4, 1'b1)
         xfer(1'b0, `OFS_CONV_CONTROL_0, 32'h0);
         `CHK(q, 32'h01)
         `CHK(smp, 1'b1)
         xfer(1'b0, `OFS_CONV_STATUS, 32'h0);
         `CHK(q, 32'h01)
         hi = k[0] ? v >> 8 : v >> 2;
         lo = k[0] ? v & 255 : (v & 3) << 6;
         results();
         xfer(1'b1, `OFS_CONV_STATUS, 32'h01);
      end
      // abort once bits 9 and 8 are decided: the rest copy bit 8
      xfer(1'b1, `OFS_CONV_CONTROL_1, 32'hE0);
      xfer(1'b1, `OFS_CONV_CONTROL_0, 32'h03);
      while (trial[7] !== 1'b1) @(posedge clock);
      xfer(1'b1, `OFS_CONV_CONTROL_0, 32'h01);
      repeat (3) @(posedge clock);
      `CHK(flag, 1'b1)
      hi = v >> 8;
      lo = v[8] ? 255 : 0;
      results();
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      results();
      xfer(1'b0, `OFS_CONV_CONTROL_1, 32'h0);
      `CHK(q, 32'h0)
      print_verdict();
   end
endmodule

//--- tb/analog_front_model.sv
// analog side model: comparator on a held input level, rc oscillator ticks
`timescale 1ns/1ps

module analog_front_model #(
   parameter int RC_PERIOD = 5
) (
   input wire logic clock,
   input wire logic [9:0] level,
   input wire logic [9:0] trial_code,
   output logic comparator_high,
   output logic rc_osc_tick
);
   int cnt = 0;
   initial rc_osc_tick = 1'b0;
   // level sits half a step above its code, so a tie never decides a bit
   // the held level is never discharged between conversions
   assign comparator_high = {level, 1'b1} > {trial_code, 1'b0};
   always @(posedge clock) begin
      cnt <= (cnt == RC_PERIOD - 1) ? 0 : cnt + 1;
      rc_osc_tick <= (cnt == 0);
   end
endmodule
